// >>> twowire_pkg.sv
// Shared constants and types for both ends of the two-wire slave port
//
// Contract
// [R1] Master makes every clock, START and STOP
// [R2] Master starts only when both lines high
// [R3] Data never changes while clock high
// [R4] Slave sees data fall, clock high: START
// [R5] Slave sees data rise, clock high: STOP
// [R6] Drive changes on clock low, sample high
// [R7] Eight bits plus ack; master sets count
// [R8] Slave works at 100 and 400 kHz
// [R9] Addressed receiver holds data low during ack
// [R10] After master not-ack, slave releases data
// [R11] Write: address then data, each acked
// [R12] Read: slave sends, master nacks last byte
// [R13] Repeated START ends and begins a transfer
// [R14] Address matched in hardware after eight bits
// [R15] Transmitting slave still takes clock as input
// [R16] Control byte top nibble must be 1001
// [R17] Device select bits must equal 000
// [R18] Last control bit: one read, zero write
// [R19] Acknowledge only when code and select match
// [R20] First written byte loads pointer, resets 00h
// [R21] Master sends pointer before every data write
// [R22] Data bytes travel most significant bit first
// [R23] Mismatch: stay released until next START
package twowire_pkg;
  // Control byte identity
  localparam logic [3:0] TYPE_CODE = 4'h9;
  localparam logic DEVICE_SELECT_BIT_HIGH = 1'h0;
  localparam logic DEVICE_SELECT_BIT_MID = 1'h0;
  localparam logic DEVICE_SELECT_BIT_LOW = 1'h0;
  localparam logic [2:0] DEVICE_SELECT = {DEVICE_SELECT_BIT_HIGH,
    DEVICE_SELECT_BIT_MID, DEVICE_SELECT_BIT_LOW};
  localparam logic DIR_READ = 1'h1;
  // Pointer value after reset
  localparam logic [7:0] POINTER_RESET = 8'h00;
  // Bit counters
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // Event toggle positions, link side to core side
  localparam int EV_BYTE = 0;
  localparam int EV_MATCH = 1;
  localparam int EV_STOP = 2;
  localparam int EV_REQ = 3;
  localparam int EV_W = 4;
  // Master clock divider: four quarters per bit
  localparam int CLOCK_KHZ = 40000;
  localparam int LINK_KHZ = 400;
  localparam int QUARTER_INT = CLOCK_KHZ / (4 * LINK_KHZ);
  localparam logic [7:0] QUARTER_CYCLES = 8'(QUARTER_INT);
  // Slave link states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_ACK = 3'h3,
    S_RX = 3'h2,
    S_TX = 3'h6,
    S_MACK = 3'h7
  } slave_state_t;
  // Master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_START = 2'h1,
    M_BIT = 2'h3,
    M_STOP = 2'h2
  } master_state_t;
  // Master commands
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ = 2'h3
  } cmd_t;
endpackage : twowire_pkg

// >>> twowire_if.sv
// Open-drain two-wire bus joining master and slave ends
`timescale 1ns/1ps
`default_nettype none
interface twowire_if;
  // Master pin drives
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  // Slave pin drive
  logic sda_s_o;
  logic sda_s_oe;
  // Resolved wire levels, pulled high when nobody pulls low
  logic scl;
  logic sda;
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
  // Bus master end
  modport master (
    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
    input sda
  );
  // Slave device end
  modport device (
    output sda_s_o, sda_s_oe,
    input scl, sda
  );
endinterface : twowire_if
`default_nettype wire

// >>> twowire_slave_end.sv
// Slave end of the two-wire port, link logic clocked by the bus clock
`timescale 1ns/1ps
`default_nettype none
module twowire_slave_end (
  // Core clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Bus pins
  twowire_if.device bus,
  // Register pointer and written data
  output logic [7:0] pointer_out,
  output logic [7:0] wr_data_out,
  output logic wr_valid_out,
  // Read data request and answer
  output logic rd_req_out,
  input wire logic [7:0] rd_data_in,
  // Addressed between match and STOP
  output logic busy_out
);

  // Bus condition toggles, clocked by data line edges
  logic start_tog_reg;
  logic stop_tog_reg;

  // Link state, clocked by the bus clock
  twowire_pkg::slave_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_byte_reg;
  logic start_seen_reg;
  logic rw_reg;
  logic ptr_next_reg;
  logic is_ptr_reg;
  logic byte_tog_reg;
  logic match_tog_reg;
  logic req_tog_reg;
  logic drive_low_reg;

  // Core side state
  logic [twowire_pkg::EV_W-1:0] sync1_reg;
  logic [twowire_pkg::EV_W-1:0] sync2_reg;
  logic [twowire_pkg::EV_W-1:0] sync3_reg;
  logic [7:0] pointer_reg;
  logic [7:0] wr_data_reg;
  logic wr_valid_reg;
  logic rd_req_reg;
  logic rd_take_reg;
  logic [7:0] tx_data_reg;
  logic busy_reg;

  // Decoding on the link side
  wire logic start_new;
  wire logic [7:0] byte_in;
  wire logic last_bit;
  wire logic addr_hit;
  wire logic drive_next;
  // Core side events
  wire logic [twowire_pkg::EV_W-1:0] link_tog;
  wire logic [twowire_pkg::EV_W-1:0] ev;

  // A START not yet seen by the bus clock logic
  assign start_new = start_tog_reg != start_seen_reg;
  // Byte assembled MSB first with the bit on the line now
  assign byte_in = {shift_reg[6:0], bus.sda}; // R22
  assign last_bit = bit_cnt_reg == twowire_pkg::LAST_BIT;
  // Both type code and device select must match
  assign addr_hit = (byte_in[7:4] == twowire_pkg::TYPE_CODE) && // R16
    (byte_in[3:1] == twowire_pkg::DEVICE_SELECT); // R17
  // Pull low for ack, or for a zero bit while sending
  assign drive_next = (state_reg == twowire_pkg::S_ACK) || // R9
    ((state_reg == twowire_pkg::S_TX) && !tx_shift_reg[7]); // R15

  // Open drain: only ever pulls low
  assign bus.sda_s_o = 1'h0;
  assign bus.sda_s_oe = drive_low_reg;

  // START: data falls while clock high
  always_ff @(negedge bus.sda or negedge rstn_in) begin
    if (!rstn_in) begin
      start_tog_reg <= 1'h0;
    end else if (bus.scl) begin
      start_tog_reg <= !start_tog_reg; // R4
    end
  end

  // STOP: data rises while clock high
  always_ff @(posedge bus.sda or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_tog_reg <= 1'h0;
    end else if (bus.scl) begin
      stop_tog_reg <= !stop_tog_reg; // R5
    end
  end

  // Sample on the rising clock edge, step the link state
  always_ff @(posedge bus.scl or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= twowire_pkg::S_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'hFF;
      rx_byte_reg <= 8'h00;
      start_seen_reg <= 1'h0;
      rw_reg <= 1'h0;
      ptr_next_reg <= 1'h0;
      is_ptr_reg <= 1'h0;
      byte_tog_reg <= 1'h0;
      match_tog_reg <= 1'h0;
      req_tog_reg <= 1'h0;
    end else begin
      start_seen_reg <= start_tog_reg;
      shift_reg <= byte_in; // R6
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (start_new) begin
        // First address bit taken on this edge, even mid-transfer
        state_reg <= twowire_pkg::S_ADDR; // R13
        bit_cnt_reg <= 3'h1;
      end else begin
        unique case (state_reg)
          // Not addressed: ignore all until next START
          twowire_pkg::S_IDLE: begin
            state_reg <= twowire_pkg::S_IDLE; // R23
          end
          // Control byte arriving
          twowire_pkg::S_ADDR: begin
            if (last_bit) begin
              if (addr_hit) begin // R14
                state_reg <= twowire_pkg::S_ACK; // R19
                rw_reg <= byte_in[0]; // R18
                ptr_next_reg <= byte_in[0] != twowire_pkg::DIR_READ; // R20
                match_tog_reg <= !match_tog_reg;
                // Ask the core for the first read byte
                if (byte_in[0] == twowire_pkg::DIR_READ) begin
                  req_tog_reg <= !req_tog_reg; // R12
                end
              end else begin
                state_reg <= twowire_pkg::S_IDLE; // R23
              end
            end
          end
          // Our ack on the line; choose direction afterwards
          twowire_pkg::S_ACK: begin
            bit_cnt_reg <= 3'h0;
            if (rw_reg == twowire_pkg::DIR_READ) begin
              state_reg <= twowire_pkg::S_TX;
              tx_shift_reg <= tx_data_reg;
            end else begin
              state_reg <= twowire_pkg::S_RX; // R11
            end
          end
          // Receiving a data byte; every byte is acked
          twowire_pkg::S_RX: begin
            if (last_bit) begin
              rx_byte_reg <= byte_in;
              is_ptr_reg <= ptr_next_reg; // R20
              ptr_next_reg <= 1'h0;
              byte_tog_reg <= !byte_tog_reg;
              state_reg <= twowire_pkg::S_ACK; // R11
            end
          end
          // Sending a byte, next bit shifted up
          twowire_pkg::S_TX: begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'h1}; // R22
            if (last_bit) begin
              state_reg <= twowire_pkg::S_MACK; // R7
              req_tog_reg <= !req_tog_reg;
            end
          end
          // Master answer: ack continues, not-ack ends
          twowire_pkg::S_MACK: begin
            bit_cnt_reg <= 3'h0;
            if (!bus.sda) begin
              state_reg <= twowire_pkg::S_TX; // R12
              tx_shift_reg <= tx_data_reg;
            end else begin
              state_reg <= twowire_pkg::S_IDLE; // R10
            end
          end
          // Unused codes fall back to idle
          default: begin
            state_reg <= twowire_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Change the data line only on the falling clock edge
  always_ff @(negedge bus.scl or negedge rstn_in) begin
    if (!rstn_in) begin
      drive_low_reg <= 1'h0;
    end else begin
      drive_low_reg <= drive_next; // R6
    end
  end

  // Link events gathered for the core crossing
  assign link_tog[twowire_pkg::EV_BYTE] = byte_tog_reg;
  assign link_tog[twowire_pkg::EV_MATCH] = match_tog_reg;
  assign link_tog[twowire_pkg::EV_STOP] = stop_tog_reg;
  assign link_tog[twowire_pkg::EV_REQ] = req_tog_reg;
  // A changed toggle marks one event
  assign ev = sync2_reg ^ sync3_reg;

  // Two-stage synchroniser plus edge memory
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= link_tog; // R8
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Received byte goes to pointer or to write data
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pointer_reg <= twowire_pkg::POINTER_RESET; // R20
      wr_data_reg <= 8'h00;
      wr_valid_reg <= 1'h0;
    end else begin
      wr_valid_reg <= ev[twowire_pkg::EV_BYTE] && !is_ptr_reg;
      // Link byte is stable for a whole byte time
      if (ev[twowire_pkg::EV_BYTE] && is_ptr_reg) begin
        pointer_reg <= rx_byte_reg; // R20
      end
      if (ev[twowire_pkg::EV_BYTE] && !is_ptr_reg) begin
        wr_data_reg <= rx_byte_reg;
      end
    end
  end

  // Read request, answer taken one cycle later
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_req_reg <= 1'h0;
      rd_take_reg <= 1'h0;
      tx_data_reg <= 8'hFF;
    end else begin
      rd_req_reg <= ev[twowire_pkg::EV_REQ];
      rd_take_reg <= rd_req_reg;
      if (rd_take_reg) begin
        tx_data_reg <= rd_data_in;
      end
    end
  end

  // Busy from address match until STOP; match wins a tie
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_reg <= 1'h0;
    end else if (ev[twowire_pkg::EV_MATCH]) begin
      busy_reg <= 1'h1;
    end else if (ev[twowire_pkg::EV_STOP]) begin
      busy_reg <= 1'h0; // R5
    end
  end

  // Outputs straight from flip-flops
  assign pointer_out = pointer_reg;
  assign wr_data_out = wr_data_reg;
  assign wr_valid_out = wr_valid_reg;
  assign rd_req_out = rd_req_reg;
  assign busy_out = busy_reg;

endmodule : twowire_slave_end
`default_nettype wire

// >>> twowire_master_end.sv
// Master end of the two-wire port: clock divider and bit sequencer
`timescale 1ns/1ps
`default_nettype none
module twowire_master_end (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Bus pins
  twowire_if.master bus,
  // Command port
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_code_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_last_in,
  output logic cmd_ready_out,
  // Result port
  output logic done_out,
  output logic [7:0] rd_data_out,
  output logic ack_out
);

  // Sequencer state
  twowire_pkg::master_state_t state_reg;
  logic [7:0] tick_cnt_reg;
  logic [1:0] quarter_reg;
  logic [3:0] bit_idx_reg;
  logic [8:0] tx_reg;
  logic [8:0] rx_reg;
  // Pin drives, high pulls the line low
  logic scl_low_reg;
  logic sda_low_reg;
  // Result registers
  logic ready_reg;
  logic done_reg;
  logic [7:0] rd_data_reg;
  logic ack_reg;
  // Data line synchroniser
  logic sda_meta_reg;
  logic sda_sync_reg;

  // Decoding
  wire logic tick;
  wire logic take;
  wire logic bit_end;
  assign tick = tick_cnt_reg == (twowire_pkg::QUARTER_CYCLES - 8'h01);
  assign take = ready_reg && cmd_valid_in;
  assign bit_end = bit_idx_reg == twowire_pkg::ACK_BIT;

  // Open-drain drives
  assign bus.scl_m_o = 1'h0;
  assign bus.scl_m_oe = scl_low_reg; // R1
  assign bus.sda_m_o = 1'h0;
  assign bus.sda_m_oe = sda_low_reg;

  // Bring the data line into the core clock
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_meta_reg <= 1'h1;
      sda_sync_reg <= 1'h1;
    end else begin
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // Quarter-bit divider, halted while idle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt_reg <= 8'h00;
      quarter_reg <= 2'h0;
    end else if (state_reg == twowire_pkg::M_IDLE) begin
      tick_cnt_reg <= 8'h00;
      quarter_reg <= 2'h0;
    end else if (tick) begin
      tick_cnt_reg <= 8'h00;
      quarter_reg <= quarter_reg + 2'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  // Bit sequencer
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= twowire_pkg::M_IDLE;
      bit_idx_reg <= 4'h0;
      tx_reg <= 9'h1FF;
      rx_reg <= 9'h000;
      scl_low_reg <= 1'h0;
      sda_low_reg <= 1'h0;
      ready_reg <= 1'h1;
      done_reg <= 1'h0;
      rd_data_reg <= 8'h00;
      ack_reg <= 1'h0;
    end else begin
      done_reg <= 1'h0;
      unique case (state_reg)
        // Wait for a command
        twowire_pkg::M_IDLE: begin
          if (take) begin
            ready_reg <= 1'h0;
            bit_idx_reg <= 4'h0;
            unique case (cmd_code_in)
              twowire_pkg::CMD_START: state_reg <= twowire_pkg::M_START;
              twowire_pkg::CMD_STOP: state_reg <= twowire_pkg::M_STOP;
              // Byte MSB first, then release for slave ack
              twowire_pkg::CMD_WRITE: begin
                tx_reg <= {cmd_data_in, 1'h1}; // R11
                state_reg <= twowire_pkg::M_BIT;
              end
              // Release eight bits, then ack or not-ack
              twowire_pkg::CMD_READ: begin
                tx_reg <= {8'hFF, cmd_last_in}; // R12
                state_reg <= twowire_pkg::M_BIT;
              end
            endcase
          end
        end
        // START or repeated START from either clock level
        twowire_pkg::M_START: begin
          if (tick) begin
            unique case (quarter_reg)
              2'h0: sda_low_reg <= 1'h0; // R2
              2'h1: scl_low_reg <= 1'h0;
              2'h2: sda_low_reg <= 1'h1; // R13
              2'h3: begin
                scl_low_reg <= 1'h1;
                state_reg <= twowire_pkg::M_IDLE;
                ready_reg <= 1'h1;
                done_reg <= 1'h1;
              end
            endcase
          end
        end
        // One bit: set data to the bit, raise clock, sample, lower clock
        twowire_pkg::M_BIT: begin
          if (tick) begin
            unique case (quarter_reg)
              2'h0: sda_low_reg <= !tx_reg[8]; // R6
              2'h1: scl_low_reg <= 1'h0;
              2'h2: rx_reg <= {rx_reg[7:0], sda_sync_reg}; // R3
              2'h3: begin
                scl_low_reg <= 1'h1;
                tx_reg <= {tx_reg[7:0], 1'h1};
                bit_idx_reg <= bit_idx_reg + 4'h1;
                if (bit_end) begin
                  state_reg <= twowire_pkg::M_IDLE; // R7
                  ready_reg <= 1'h1;
                  done_reg <= 1'h1;
                  rd_data_reg <= rx_reg[8:1];
                  ack_reg <= !rx_reg[0];
                end
              end
            endcase
          end
        end
        // STOP: data rises while clock high, bus left idle
        twowire_pkg::M_STOP: begin
          if (tick) begin
            unique case (quarter_reg)
              2'h0: sda_low_reg <= 1'h1;
              2'h1: scl_low_reg <= 1'h0;
              2'h2: sda_low_reg <= 1'h0; // R1
              2'h3: begin
                state_reg <= twowire_pkg::M_IDLE;
                ready_reg <= 1'h1;
                done_reg <= 1'h1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign cmd_ready_out = ready_reg;
  assign done_out = done_reg;
  assign rd_data_out = rd_data_reg;
  assign ack_out = ack_reg;

endmodule : twowire_master_end
`default_nettype wire

// >>> twowire_link_properties.sv
// Concurrent checks on the two-wire link between both ends
`timescale 1ns/1ps
`default_nettype none
module twowire_link_properties (
  // Core clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Resolved lines and slave drive
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  // Line levels one cycle back
  logic scl_reg;
  logic sda_reg;
  // Bit count, shifted byte and transfer flags
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic first_reg;
  logic addr_reg;
  logic read_reg;
  logic quiet_reg;
  // Clock high and low run lengths
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  // Bus conditions and expected ninth bit
  wire start_w = scl && scl_reg && sda_reg && !sda;
  wire stop_w = scl && scl_reg && !sda_reg && sda;
  wire rise_w = scl && !scl_reg;
  wire ack_bit_w = rise_w && bit_reg == 4'h8;
  wire addr_ok_w = shift_reg[7:1] ==
    {twowire_pkg::TYPE_CODE, twowire_pkg::DEVICE_SELECT};
  wire ack_exp_w = first_reg ? addr_ok_w : (addr_reg && !read_reg);
  // Line history and saturating run lengths
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
      hi_reg <= 8'h00;
      lo_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      hi_reg <= !scl ? 8'h00 : (hi_reg == 8'hFF ? hi_reg : hi_reg + 8'h01);
      lo_reg <= scl ? 8'h00 : (lo_reg == 8'hFF ? lo_reg : lo_reg + 8'h01);
    end
  end
  // Byte framing from START to STOP
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      first_reg <= 1'h0;
      addr_reg <= 1'h0;
      read_reg <= 1'h0;
      quiet_reg <= 1'h1;
    end else if (start_w) begin
      bit_reg <= 4'h0;
      first_reg <= 1'h1;
      addr_reg <= 1'h0;
      quiet_reg <= 1'h0;
    end else if (stop_w) begin
      addr_reg <= 1'h0;
      quiet_reg <= 1'h1;
    end else if (rise_w && bit_reg != 4'h8) begin
      bit_reg <= bit_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], sda};
    end else if (rise_w) begin
      bit_reg <= 4'h0;
      first_reg <= 1'h0;
      addr_reg <= first_reg ? addr_ok_w : addr_reg;
      read_reg <= first_reg ? shift_reg[0] : read_reg;
      quiet_reg <= quiet_reg || (first_reg && !addr_ok_w) ||
        (!first_reg && read_reg && sda);
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);
  property p_slave_edge;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_slave_edge: assert property (p_slave_edge)
    else $error("slave data drive moved while clock high");
  property p_ack_hold;
    $rose(scl) && sda_s_oe |-> sda_s_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("slave low drive dropped during clock high");
  property p_ack_match;
    ack_bit_w |-> sda_s_oe == ack_exp_w;
  endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("slave ninth bit drive wrong");
  property p_quiet;
    quiet_reg |-> !sda_s_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("slave drives data while it should be released");
  property p_start_idle;
    start_w |-> $past(scl, 8) && $past(sda, 8);
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("start without both lines high beforehand");
  property p_scl_high;
    $fell(scl) |-> hi_reg >= 8'h28;
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high time too short");
  property p_scl_low;
    $rose(scl) |-> lo_reg >= 8'h28;
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low time too short");
  property p_stop_bound;
    stop_w |-> bit_reg == 4'h1;
  endproperty
  a_stop_bound: assert property (p_stop_bound)
    else $error("stop placed inside a byte");
  // Main scenarios reached
  c_read_hit: cover property (ack_bit_w && first_reg && addr_ok_w &&
    shift_reg[0]);
  c_miss: cover property (ack_bit_w && first_reg && !addr_ok_w);
  c_restart: cover property (start_w && !quiet_reg);
endmodule : twowire_link_properties
`default_nettype wire

// >>> thermometer_twowire_slave_port_tb_top.sv
// Self-checking bench joining master and slave ends over one bus
`timescale 1ns/1ps
`default_nettype none
module thermometer_twowire_slave_port_tb_top;
  // Clock, reset and master command inputs
  logic clock_in = 1'h0;
  // Starts high so that lowering it gives every reset a real edge
  logic rstn_in = 1'h1;
  logic cmd_valid_in = 1'h0;
  logic [1:0] cmd_code_in = 2'h0;
  logic [7:0] cmd_data_in = 8'h00;
  logic cmd_last_in = 1'h0;
  logic [7:0] rd_data_in = 8'h00;
  // Design outputs
  logic cmd_ready_out, done_out, ack_out, wr_valid_out, rd_req_out;
  logic busy_out;
  logic [7:0] rd_data_out, pointer_out, wr_data_out;
  // Model state and counters
  integer err_total = 0;
  integer samples_checked = 0;
  integer seed = 7;
  logic [7:0] model_ptr = 8'h00;
  logic [7:0] rd_q[$];
  logic [7:0] wr_q[$];
  logic [7:0] wr_got[$];
  localparam int LIMIT = 2000;
  localparam logic [7:0] ADDR_W = {twowire_pkg::TYPE_CODE,
    twowire_pkg::DEVICE_SELECT, 1'h0};
  localparam logic [7:0] ADDR_R = ADDR_W | 8'h01;
  // Bus and both ends
  twowire_if bus_if ();
  twowire_master_end u_twowire_master_end (.clock_in, .rstn_in,
    .bus(bus_if), .cmd_valid_in, .cmd_code_in, .cmd_data_in, .cmd_last_in,
    .cmd_ready_out, .done_out, .rd_data_out, .ack_out);
  twowire_slave_end u_twowire_slave_end (.clock_in, .rstn_in,
    .bus(bus_if), .pointer_out, .wr_data_out, .wr_valid_out, .rd_req_out,
    .rd_data_in, .busy_out);
  twowire_link_properties chk (.clock_in, .rstn_in,
    .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  // Core clock
  initial begin
    forever #12.5 clock_in = !clock_in;
  end
  // Fresh read byte per request, capture of written bytes
  always @(negedge clock_in) begin
    if (rd_req_out === 1'h1) begin
      rd_data_in = 8'($random(seed));
      rd_q.push_back(rd_data_in);
    end
    if (wr_valid_out === 1'h1) wr_got.push_back(wr_data_out);
  end
  // Counts and verdict, then end of run
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // One comparison
  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One master command, bounded waits for take and finish
  task automatic cmd(input logic [1:0] code, input logic [7:0] data,
    input logic last);
    integer n;
    n = 0;
    cmd_code_in = code;
    cmd_data_in = data;
    cmd_last_in = last;
    cmd_valid_in = 1'h1;
    while (cmd_ready_out !== 1'h1 && n < LIMIT) begin
      @(negedge clock_in);
      n++;
    end
    @(negedge clock_in);
    cmd_valid_in = 1'h0;
    while (done_out !== 1'h1 && n < LIMIT) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= LIMIT) begin
      err_total++;
      $display("Error command wait expected done seen timeout");
      print_verdict();
    end
  endtask : cmd
  // Written byte and its ninth bit
  task automatic put(input logic [7:0] data, input logic exp_ack);
    cmd(twowire_pkg::CMD_WRITE, data, 1'h0);
    check("ack", {7'h0, exp_ack}, {7'h0, ack_out});
  endtask : put
  // Read byte against the supplied stream
  task automatic get(input logic last);
    logic [7:0] exp;
    cmd(twowire_pkg::CMD_READ, 8'h00, last);
    exp = rd_q.size() > 0 ? rd_q.pop_front() : 8'h00;
    check("read byte", exp, rd_data_out);
  endtask : get
  // START plus control byte
  task automatic start_addr(input logic [7:0] addr, input logic hit);
    cmd(twowire_pkg::CMD_START, 8'h00, 1'h0);
    put(addr, hit);
    if (hit) check("busy", 8'h01, {7'h0, busy_out});
  endtask : start_addr
  // STOP, then released and pointer kept
  task automatic stop_chk;
    cmd(twowire_pkg::CMD_STOP, 8'h00, 1'h0);
    check("busy after stop", 8'h00, {7'h0, busy_out});
    check("pointer", model_ptr, pointer_out);
  endtask : stop_chk
  // Main sequence
  initial begin
    logic [7:0] addr;
    logic hit;
    integer j;
    // Falling edge reaches the line-clocked flops too
    #1 rstn_in = 1'h0;
    repeat (10) @(negedge clock_in);
    rstn_in = 1'h1;
    @(negedge clock_in);
    check("pointer reset", twowire_pkg::POINTER_RESET, pointer_out);
    // Every type code, every device select, both directions
    for (j = 0; j < 24; j++) begin
      addr = j < 16 ? {4'(j), 3'h0, j[0]} :
        {twowire_pkg::TYPE_CODE, 3'(j), j[0]};
      hit = addr[7:1] == ADDR_W[7:1];
      rd_q.delete();
      start_addr(addr, hit);
      if (!hit) put(8'($random(seed)), 1'h0);
      else if (addr[0]) get(1'h1);
      stop_chk();
    end
    // Pointer then three data bytes
    wr_got.delete();
    start_addr(ADDR_W, 1'h1);
    model_ptr = 8'($random(seed));
    put(model_ptr, 1'h1);
    for (j = 0; j < 3; j++) begin
      addr = 8'($random(seed));
      wr_q.push_back(addr);
      put(addr, 1'h1);
    end
    stop_chk();
    check("write count", 8'(wr_q.size()), 8'(wr_got.size()));
    foreach (wr_q[i]) check("write data", wr_q[i], wr_got[i]);
    // New pointer, repeated START, read of four bytes
    start_addr(ADDR_W, 1'h1);
    model_ptr = 8'($random(seed));
    put(model_ptr, 1'h1);
    rd_q.delete();
    start_addr(ADDR_R, 1'h1);
    for (j = 0; j < 4; j++) get(j == 3);
    stop_chk();
    // Read with kept pointer, then restart to another device
    rd_q.delete();
    start_addr(ADDR_R, 1'h1);
    get(1'h1);
    start_addr({twowire_pkg::TYPE_CODE, 3'h5, 1'h1}, 1'h0);
    put(8'($random(seed)), 1'h0);
    stop_chk();
    print_verdict();
  end
endmodule : thermometer_twowire_slave_port_tb_top
`default_nettype wire
